/* rtl/periph_flag_pkg.sv */
// Package with offsets, bit positions, masks and modes of the peripheral flag bank.
package periph_flag_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] PERIPH_FLAG_REG3_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] PERIPH_FLAG_REG4_OFFSET = 4'h1;
    localparam logic [ADDR_W-1:0] PERIPH_FLAG_REG5_OFFSET = 4'h2;
    localparam logic [ADDR_W-1:0] PERIPH_FLAG_REG6_OFFSET = 4'h3;
    localparam int NUM_REGS = 4;
    localparam int NUM_CAPCMP = 10;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TIMER5_GATE_BIT = 7;
    localparam int SERIAL2_RX_BIT = 5;
    localparam int SERIAL2_TX_BIT = 4;
    localparam int CHARGE_TIME_BIT = 3;
    localparam int CAPCMP2_BIT = 2;
    localparam int CAPCMP1_BIT = 1;
    localparam int RTC_BIT = 0;
    localparam int TIMER7_GATE_BIT = 7;
    localparam int TIMER12_MATCH_BIT = 6;
    localparam int TIMER10_MATCH_BIT = 5;
    localparam int TIMER8_MATCH_BIT = 4;
    localparam int TIMER7_OVF_BIT = 3;
    localparam int TIMER6_MATCH_BIT = 2;
    localparam int TIMER5_OVF_BIT = 1;
    localparam int TIMER4_MATCH_BIT = 0;
    localparam int NV_WRITE_DONE_BIT = 4;
    localparam int COMPARATOR3_BIT = 2;
    localparam int COMPARATOR2_BIT = 1;
    localparam int COMPARATOR1_BIT = 0;

    // ************************************************************
    // Masks of sticky, software-clearable bits per variant
    // ************************************************************
    localparam logic [7:0] REG3_STICKY_MASK = 8'h8F;
    localparam logic [7:0] REG4_STICKY_MASK_LARGE = 8'hFF;
    localparam logic [7:0] REG4_STICKY_MASK_SMALL = 8'h3F;
    localparam logic [7:0] REG5_STICKY_MASK_LARGE = 8'hFF;
    localparam logic [7:0] REG5_STICKY_MASK_SMALL = 8'h17;
    localparam logic [7:0] REG6_STICKY_MASK = 8'h17;

    typedef enum logic [1:0] {
        CAPCMP_OFF,
        CAPCMP_CAPTURE,
        CAPCMP_COMPARE,
        CAPCMP_PWM
    } capcmp_mode_t;

endpackage : periph_flag_pkg

/* rtl/capcmp_event_qual.sv */
// Mode qualifier that turns capture/compare unit events into flag set requests.
`timescale 1ns/1ps
module capcmp_event_qual
    import periph_flag_pkg::*;
(
    input wire logic [1:0] mode_i,
    input wire logic capture_i,
    input wire logic match_i,
    output logic set_o
);

    capcmp_mode_t mode;

    always_comb
    begin
        mode = capcmp_mode_t'(mode_i);
        set_o = 1'b0;
        case (mode)
            CAPCMP_CAPTURE: set_o = capture_i;
            CAPCMP_COMPARE: set_o = match_i;
            // PWM drives the pin only, so a period end is not an event here.
            CAPCMP_PWM: set_o = 1'b0;
            default: set_o = 1'b0;
        endcase
    end

endmodule : capcmp_event_qual

/* rtl/sticky_flag_bit.sv */
// One sticky event flag that hardware sets and software writes.
`timescale 1ns/1ps
module sticky_flag_bit
#(
    parameter bit PRESENT = 1'b1
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic wr_i,
    input wire logic wdata_i,
    output logic flag_o
);

    logic flag;
    logic next_flag;

    always_comb
    begin
        next_flag = flag;
        if (wr_i)
        begin
            next_flag = wdata_i;
        end
        // A set in the same cycle as a clearing write wins, so no event is lost.
        if (set_i)
        begin
            next_flag = 1'b1;
        end
        if (!PRESENT)
        begin
            next_flag = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flag <= 1'b0;
        end
        else
        begin
            flag <= next_flag;
        end
    end

    assign flag_o = flag;

endmodule : sticky_flag_bit

/* rtl/periph_flag_bank.sv */
// Top of the bank of four peripheral interrupt request flag registers.
`timescale 1ns/1ps
module periph_flag_bank
    import periph_flag_pkg::*;
#(
    parameter bit LARGE_MEMORY = 1'b1,
    parameter int BUS_ADDR_W = ADDR_W
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [BUS_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rd_data_o,
    input wire logic timer5_gate_i,
    input wire logic serial2_rx_full_i,
    input wire logic serial2_tx_empty_i,
    input wire logic charge_time_unit_i,
    input wire logic rtc_event_i,
    input wire logic [2*NUM_CAPCMP-1:0] capcmp_mode_i,
    input wire logic [NUM_CAPCMP-1:0] capcmp_capture_i,
    input wire logic [NUM_CAPCMP-1:0] capcmp_match_i,
    input wire logic timer7_gate_i,
    input wire logic timer12_period_match_i,
    input wire logic timer10_period_match_i,
    input wire logic timer8_period_match_i,
    input wire logic timer7_overflow_i,
    input wire logic timer6_period_match_i,
    input wire logic timer5_overflow_i,
    input wire logic timer4_period_match_i,
    input wire logic nv_write_done_i,
    input wire logic comparator3_i,
    input wire logic comparator2_i,
    input wire logic comparator1_i,
    output logic [7:0] periph_flag_reg3_o,
    output logic [7:0] periph_flag_reg4_o,
    output logic [7:0] periph_flag_reg5_o,
    output logic [7:0] periph_flag_reg6_o
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (BUS_ADDR_W != ADDR_W)
    begin : g_bad_addr_w
        $error("periph_flag_bank: address width must match the register map");
    end

    // ************************************************************
    // Variant masks and write decode
    // ************************************************************
    localparam logic [7:0] REG4_MASK =
        LARGE_MEMORY ? REG4_STICKY_MASK_LARGE : REG4_STICKY_MASK_SMALL;
    localparam logic [7:0] REG5_MASK =
        LARGE_MEMORY ? REG5_STICKY_MASK_LARGE : REG5_STICKY_MASK_SMALL;
    localparam logic [8*NUM_REGS-1:0] STICKY_MASK =
        {REG6_STICKY_MASK, REG5_MASK, REG4_MASK, REG3_STICKY_MASK};

    logic [NUM_REGS-1:0] reg_wr;
    logic [NUM_CAPCMP-1:0] capcmp_set;
    logic [7:0] set3;
    logic [7:0] set4;
    logic [7:0] set5;
    logic [7:0] set6;
    logic [8*NUM_REGS-1:0] set_all;
    logic [8*NUM_REGS-1:0] flag_all;
    logic serial2_rx_full;
    logic serial2_tx_empty;
    logic [7:0] reg3_view;
    logic [7:0] next_rd_data;

    always_comb
    begin
        reg_wr = '0;
        if (wr_i)
        begin
            case (addr_i)
                PERIPH_FLAG_REG3_OFFSET: reg_wr[0] = 1'b1;
                PERIPH_FLAG_REG4_OFFSET: reg_wr[1] = 1'b1;
                PERIPH_FLAG_REG5_OFFSET: reg_wr[2] = 1'b1;
                PERIPH_FLAG_REG6_OFFSET: reg_wr[3] = 1'b1;
                default: reg_wr = '0;
            endcase
        end
    end

    // ************************************************************
    // Capture/compare unit qualifiers
    // ************************************************************
    for (genvar u = 0; u < NUM_CAPCMP; u++)
    begin : g_capcmp
        capcmp_event_qual u_qual (
            .mode_i(capcmp_mode_i[2*u+1:2*u]),
            .capture_i(capcmp_capture_i[u]),
            .match_i(capcmp_match_i[u]),
            .set_o(capcmp_set[u])
        );
    end

    // ************************************************************
    // Event routing; enables are not looked at, so polling works
    // ************************************************************
    always_comb
    begin
        set3 = 8'h00;
        set3[TIMER5_GATE_BIT] = timer5_gate_i;
        set3[CHARGE_TIME_BIT] = charge_time_unit_i;
        set3[CAPCMP2_BIT] = capcmp_set[1];
        set3[CAPCMP1_BIT] = capcmp_set[0];
        set3[RTC_BIT] = rtc_event_i;
        set4 = {capcmp_set[9:3], capcmp_set[2]};
        set5 = 8'h00;
        set5[TIMER7_GATE_BIT] = timer7_gate_i;
        set5[TIMER12_MATCH_BIT] = timer12_period_match_i;
        set5[TIMER10_MATCH_BIT] = timer10_period_match_i;
        set5[TIMER8_MATCH_BIT] = timer8_period_match_i;
        set5[TIMER6_MATCH_BIT] = timer6_period_match_i;
        set5[TIMER4_MATCH_BIT] = timer4_period_match_i;
        set5[TIMER7_OVF_BIT] = timer7_overflow_i;
        set5[TIMER5_OVF_BIT] = timer5_overflow_i;
        set6 = 8'h00;
        set6[NV_WRITE_DONE_BIT] = nv_write_done_i;
        set6[COMPARATOR3_BIT] = comparator3_i;
        set6[COMPARATOR2_BIT] = comparator2_i;
        set6[COMPARATOR1_BIT] = comparator1_i;
        set_all = {set6, set5, set4, set3};
    end

    // ************************************************************
    // Sticky flags; absent and unimplemented bits stay zero
    // ************************************************************
    for (genvar b = 0; b < 8*NUM_REGS; b++)
    begin : g_flag
        sticky_flag_bit #(
            .PRESENT(STICKY_MASK[b])
        ) u_flag (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .set_i(set_all[b]),
            .wr_i(reg_wr[b/8]),
            .wdata_i(wr_data_i[b%8]),
            .flag_o(flag_all[b])
        );
    end

    // ************************************************************
    // Serial buffer status bits
    // ************************************************************
    // These follow the buffer, so a software write cannot change them.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            serial2_rx_full <= 1'b0;
            serial2_tx_empty <= 1'b0;
        end
        else
        begin
            serial2_rx_full <= serial2_rx_full_i;
            serial2_tx_empty <= serial2_tx_empty_i;
        end
    end

    always_comb
    begin
        reg3_view = flag_all[7:0];
        reg3_view[SERIAL2_RX_BIT] = serial2_rx_full;
        reg3_view[SERIAL2_TX_BIT] = serial2_tx_empty;
    end

    // ************************************************************
    // Read port, data valid in the cycle after the strobe
    // ************************************************************
    always_comb
    begin
        next_rd_data = READ_UNMAPPED;
        if (rd_i)
        begin
            case (addr_i)
                PERIPH_FLAG_REG3_OFFSET: next_rd_data = reg3_view;
                PERIPH_FLAG_REG4_OFFSET: next_rd_data = flag_all[15:8];
                PERIPH_FLAG_REG5_OFFSET: next_rd_data = flag_all[23:16];
                PERIPH_FLAG_REG6_OFFSET: next_rd_data = flag_all[31:24];
                default: next_rd_data = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rd_data_o <= FLAG_RESET;
        end
        else
        begin
            rd_data_o <= next_rd_data;
        end
    end

    // ************************************************************
    // Flag views for the interrupt logic
    // ************************************************************
    // Registered copies keep outputs flop-driven at the cost of one cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            periph_flag_reg3_o <= FLAG_RESET;
            periph_flag_reg4_o <= FLAG_RESET;
            periph_flag_reg5_o <= FLAG_RESET;
            periph_flag_reg6_o <= FLAG_RESET;
        end
        else
        begin
            periph_flag_reg3_o <= reg3_view;
            periph_flag_reg4_o <= flag_all[15:8];
            periph_flag_reg5_o <= flag_all[23:16];
            periph_flag_reg6_o <= flag_all[31:24];
        end
    end

endmodule : periph_flag_bank

/* testbench/periph_flag_bank_props.sv */
// Checker with the timing and mapping assertions of the peripheral flag bank.
`timescale 1ns/1ps
module periph_flag_bank_props
    import periph_flag_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rd_data_o,
    input wire logic serial2_tx_empty_i,
    input wire logic rtc_event_i,
    input wire logic [2*NUM_CAPCMP-1:0] capcmp_mode_i,
    input wire logic [NUM_CAPCMP-1:0] capcmp_capture_i,
    input wire logic [NUM_CAPCMP-1:0] capcmp_match_i,
    input wire logic nv_write_done_i,
    input wire logic comparator1_i,
    input wire logic [7:0] periph_flag_reg3_o,
    input wire logic [7:0] periph_flag_reg5_o,
    input wire logic [7:0] periph_flag_reg6_o
);
    // ********************************
    // Assertions
    // ********************************
    logic unit1_cause;
    assign unit1_cause = (wr_i && addr_i == 4'h0 && wr_data_i[1])
        || (capcmp_mode_i[1:0] == 2'd1 && capcmp_capture_i[0])
        || (capcmp_mode_i[1:0] == 2'd2 && capcmp_match_i[0]);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    rtc_set_a: assert property (rtc_event_i |-> ##2 periph_flag_reg3_o[0])
        else $error("rtc flag not set");
    nv_done_a: assert property (nv_write_done_i |-> ##2 periph_flag_reg6_o[4])
        else $error("write done flag not set");
    unimpl_zero_a: assert property (periph_flag_reg6_o[7:5] == 3'd0 && !periph_flag_reg6_o[3]
        && !periph_flag_reg3_o[6]) else $error("unimplemented bit set");
    sticky_hold_a: assert property ($fell(periph_flag_reg3_o[7])
        |-> $past(wr_i, 2) && $past(addr_i, 2) == 4'h0) else $error("flag lost");
    pwm_quiet_a: assert property ($rose(periph_flag_reg3_o[1]) |-> $past(unit1_cause, 2))
        else $error("unit flag set without cause");
    set_wins_a: assert property (comparator1_i && wr_i && addr_i == 4'h3
        |-> ##2 periph_flag_reg6_o[0]) else $error("set lost to write");
    tx_mirror_a: assert property (!$past(rst_i) && !$past(rst_i, 2)
        |-> periph_flag_reg3_o[4] == $past(serial2_tx_empty_i, 2)) else $error("tx bit wrong");
    rd_reg5_a: assert property (rd_i && addr_i == 4'h2 |=> rd_data_o == periph_flag_reg5_o)
        else $error("read data differs");
    cover property (rd_i && addr_i == 4'h2);
    cover property ($fell(periph_flag_reg3_o[7]));
    cover property (comparator1_i && wr_i);
endmodule : periph_flag_bank_props

bind periph_flag_bank periph_flag_bank_props u_periph_flag_bank_props (.clk_i(clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .serial2_tx_empty_i(serial2_tx_empty_i), .rtc_event_i(rtc_event_i),
    .capcmp_mode_i(capcmp_mode_i), .capcmp_capture_i(capcmp_capture_i),
    .capcmp_match_i(capcmp_match_i), .nv_write_done_i(nv_write_done_i),
    .comparator1_i(comparator1_i), .periph_flag_reg3_o(periph_flag_reg3_o),
    .periph_flag_reg5_o(periph_flag_reg5_o), .periph_flag_reg6_o(periph_flag_reg6_o));

/* testbench/periph_event_model.sv */
// Behavioural model of the peripherals that raise events into the flag bank.
`timescale 1ns/1ps
module periph_event_model
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [14:0] req_i,
    input wire logic [3:0] ser_i,
    output logic [14:0] event_o,
    output logic rx_full_o,
    output logic tx_empty_o
);
    // ********************************
    // Events and serial buffer state
    // ********************************
    // Events last one cycle, since a held level would set the flag again.
    always_ff @(posedge clk_i)
    begin
        event_o <= rst_i ? 15'h0000 : req_i;
    end
    always_ff @(posedge clk_i)
    begin
        rx_full_o <= !rst_i && !ser_i[1] && (rx_full_o || ser_i[0]);
    end
    always_ff @(posedge clk_i)
    begin
        tx_empty_o <= rst_i || (!ser_i[2] && (tx_empty_o || ser_i[3]));
    end
endmodule : periph_event_model

/* testbench/test_periph_flag_bank.sv */
// Self-checking testbench of the peripheral flag bank.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module test_periph_flag_bank;
    // ********************************
    // Stimulus and checks
    // ********************************
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rx_full, tx_empty;
    logic [3:0] addr = 4'h0, ser = 4'h0, ra;
    logic [7:0] wr_data = 8'h00, rd_data, f3, f4, f5, f6, f4s, f5s;
    logic [31:0] fv;
    logic [14:0] req = 15'h0000, ev;
    logic [19:0] mode = 20'h0_0000;
    logic [9:0] cap = 10'h000, mat = 10'h000;
    int err_total = 0, n_compared = 0, rb;
    logic [15:0] rows [15] = '{16'h0080, 16'h1008, 16'h2001, 16'h3280, 16'h4240, 16'h5220,
        16'h6210, 16'h7208, 16'h8204, 16'h9202, 16'hA201, 16'hB310, 16'hC304, 16'hD302, 16'hE301};
    // The transmit buffer starts empty, and the last row leaves both status bits low.
    logic [11:0] ser_rows [5] = '{12'h030, 12'h220, 12'h330, 12'h110, 12'h200};
    always #25 clk = ~clk;
    assign fv = {f6, f5, f4, f3};
    periph_event_model u_periph_event_model (.clk_i(clk), .rst_i(rst), .req_i(req),
        .ser_i(ser), .event_o(ev), .rx_full_o(rx_full), .tx_empty_o(tx_empty));
    periph_flag_bank u_periph_flag_bank (.clk_i(clk), .rst_i(rst), .addr_i(addr),
        .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data), .timer5_gate_i(ev[0]),
        .serial2_rx_full_i(rx_full), .serial2_tx_empty_i(tx_empty), .charge_time_unit_i(ev[1]),
        .rtc_event_i(ev[2]), .capcmp_mode_i(mode), .capcmp_capture_i(cap),
        .capcmp_match_i(mat), .timer7_gate_i(ev[3]), .timer12_period_match_i(ev[4]),
        .timer10_period_match_i(ev[5]), .timer8_period_match_i(ev[6]),
        .timer7_overflow_i(ev[7]), .timer6_period_match_i(ev[8]), .timer5_overflow_i(ev[9]),
        .timer4_period_match_i(ev[10]), .nv_write_done_i(ev[11]), .comparator3_i(ev[12]),
        .comparator2_i(ev[13]), .comparator1_i(ev[14]), .periph_flag_reg3_o(f3),
        .periph_flag_reg4_o(f4), .periph_flag_reg5_o(f5), .periph_flag_reg6_o(f6));
    // A small-memory copy shares every input, so only its absent bits can differ.
    if (1'b1)
    begin : g_small
        periph_flag_bank #(.LARGE_MEMORY(1'b0)) u_periph_flag_bank (.clk_i(clk), .rst_i(rst),
            .addr_i(addr), .wr_data_i(wr_data), .wr_i(wr), .rd_i(rd), .rd_data_o(),
            .timer5_gate_i(ev[0]), .serial2_rx_full_i(rx_full), .serial2_tx_empty_i(tx_empty),
            .charge_time_unit_i(ev[1]), .rtc_event_i(ev[2]), .capcmp_mode_i(mode),
            .capcmp_capture_i(cap), .capcmp_match_i(mat), .timer7_gate_i(ev[3]),
            .timer12_period_match_i(ev[4]), .timer10_period_match_i(ev[5]),
            .timer8_period_match_i(ev[6]), .timer7_overflow_i(ev[7]),
            .timer6_period_match_i(ev[8]), .timer5_overflow_i(ev[9]),
            .timer4_period_match_i(ev[10]), .nv_write_done_i(ev[11]), .comparator3_i(ev[12]),
            .comparator2_i(ev[13]), .comparator1_i(ev[14]), .periph_flag_reg3_o(),
            .periph_flag_reg4_o(f4s), .periph_flag_reg5_o(f5s), .periph_flag_reg6_o());
    end
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= 15'h0000;
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK(rd_data, e)
    endtask : rd_chk
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++)
            rd_chk(4'(a), a == 0 ? 8'h10 : 8'h00);
        wr_reg(4'h7, 8'hFF);
        rd_chk(4'h7, 8'h00);
        for (int s = 0; s < 5; s++)
        begin
            @(posedge clk) ser <= 4'(1) << ser_rows[s][11:8];
            @(posedge clk) ser <= 4'h0;
            rd_chk(4'h0, ser_rows[s][7:0]);
            `CHK(f3, ser_rows[s][7:0])
        end
        for (int r = 0; r < 15; r++)
        begin
            @(posedge clk) req <= 15'(1) << rows[r][15:12];
            @(posedge clk) req <= 15'h0000;
            repeat (3) @(posedge clk);
            rd_chk(rows[r][11:8], rows[r][7:0]);
            `CHK(fv[8*rows[r][11:8] +: 8], rows[r][7:0])
            wr_reg(rows[r][11:8], 8'h00);
            rd_chk(rows[r][11:8], 8'h00);
        end
        for (int u = 0; u < 10; u++)
            for (int m = 1; m < 4; m++)
            begin
                ra = (u < 2) ? 4'h0 : 4'h1;
                rb = (u < 2) ? u + 1 : (u == 2 ? 0 : u - 2);
                @(posedge clk);
                mode <= {10{2'(m)}};
                cap <= (m != 2) ? 10'(1) << u : 10'h000;
                mat <= (m != 1) ? 10'(1) << u : 10'h000;
                @(posedge clk);
                cap <= 10'h000;
                mat <= 10'h000;
                rd_chk(ra, m < 3 ? 8'(1) << rb : 8'h00);
                `CHK(fv[8*ra +: 8], m < 3 ? 8'(1) << rb : 8'h00)
                wr_reg(ra, 8'h00);
            end
        // Writing ones also checks that read-only and absent bits stay clear.
        wr_reg(4'h3, 8'hFF);
        rd_chk(4'h3, 8'h17);
        wr_reg(4'h0, 8'hFF);
        rd_chk(4'h0, 8'h8F);
        wr_reg(4'h0, 8'h00);
        @(posedge clk) req <= 15'h4000;
        wr_reg(4'h3, 8'h00);
        rd_chk(4'h3, 8'h01);
        wr_reg(4'h1, 8'hFF);
        wr_reg(4'h2, 8'hFF);
        rd_chk(4'h1, 8'hFF);
        `CHK(f5, 8'hFF)
        `CHK(f4s, 8'h3F)
        `CHK(f5s, 8'h17)
        tally_and_finish();
    end
    initial
    begin
        repeat (2000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
endmodule : test_periph_flag_bank
